/* rtl/occ_pkg.sv */
//
// Purpose: Shared constants for the output compare channel.
// Assumes: AHB-Lite register window of 32-bit aligned words.
// Notes:   Codes of the mode field and of the timebase select field.
//
package occ_pkg;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  OFS_CON1    = 8'h00;
   localparam logic [7:0]  OFS_CON2    = 8'h04;
   localparam logic [7:0]  OFS_PRI     = 8'h08;
   localparam logic [7:0]  OFS_SEC     = 8'h0c;
   localparam logic [7:0]  OFS_TIMER   = 8'h10;
   localparam logic [7:0]  OFS_PERIOD  = 8'h14;
   localparam logic [7:0]  OFS_ISTAT   = 8'h18;
   localparam logic [7:0]  OFS_IMASK   = 8'h1c;

   // --------------------------------------------------------------
   // Control one field positions
   // --------------------------------------------------------------
   localparam int unsigned C1_IDLE     = 13;
   localparam int unsigned C1_TSEL_LO  = 10;
   localparam int unsigned C1_FBEN     = 8;
   localparam int unsigned C1_FAEN     = 7;
   localparam int unsigned C1_FBFLG    = 5;
   localparam int unsigned C1_FAFLG    = 4;
   localparam int unsigned C1_TCLR     = 3;
   localparam logic [15:0] C1_MASK     = 16'h3dbf;
   localparam logic [15:0] C1_RESET    = 16'h0000;

   // --------------------------------------------------------------
   // Control two field positions
   // --------------------------------------------------------------
   localparam int unsigned C2_TRUN     = 0;
   localparam int unsigned C2_TGATE    = 1;
   localparam int unsigned C2_FLVL     = 2;
   localparam logic [2:0]  C2_RESET    = 3'h0;

   // --------------------------------------------------------------
   // Interrupt status bits
   // --------------------------------------------------------------
   localparam int unsigned IRQ_W       = 4;
   localparam int unsigned IRQ_PRI     = 0;
   localparam int unsigned IRQ_SEC     = 1;
   localparam int unsigned IRQ_FAULT   = 2;
   localparam int unsigned IRQ_TRIG    = 3;

   // --------------------------------------------------------------
   // Reset values of the data registers
   // --------------------------------------------------------------
   localparam logic [15:0] PERIOD_RESET = 16'hffff;

   // --------------------------------------------------------------
   // Modes and timebase sources
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      OCC_OFF       = 3'b000,
      OCC_ONE_HIGH  = 3'b001,
      OCC_ONE_LOW   = 3'b010,
      OCC_TOGGLE    = 3'b011,
      OCC_DUAL_ONE  = 3'b100,
      OCC_DUAL_CONT = 3'b101,
      OCC_PWM_EDGE  = 3'b110,
      OCC_PWM_CTR   = 3'b111
   } occ_mode_t;

   localparam logic [2:0] TSEL_TRIGGEN   = 3'b101;
   localparam logic [2:0] TSEL_RESERVED  = 3'b110;
   localparam logic [2:0] TSEL_PERIPH    = 3'b111;
   localparam int unsigned N_TIMER_TICKS = 5;

endpackage

/* rtl/occ_timer.sv */
//
// Purpose: Channel timer with period rollover and software load.
// Assumes: One clock; tick is a one-cycle enable.
// Notes:   Held at zero while hold_clr is high and load_we is low.
//
`timescale 1ns/1ps

module occ_timer #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         tick,
   input  wire logic         hold_clr,
   input  wire logic         load_we,
   input  wire logic [W-1:0] load_val,
   input  wire logic [W-1:0] period,
   // State
   output logic      [W-1:0] count,
   output logic              wrap
);

   // --------------------------------------------------------------
   // Counter
   // --------------------------------------------------------------
   always_comb begin
      wrap = tick && !hold_clr && (count == period);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load_we) begin
         count <= load_val;
      end else if (hold_clr) begin
         count <= '0;
      end else if (wrap) begin
         count <= '0;
      end else if (tick) begin
         count <= count + W'(1);
      end
   end

endmodule

/* rtl/occ_top.sv */
//
// Purpose: Output compare channel with AHB-Lite registers.
// Assumes: All inputs synchronous to hclk; timer ticks are one-cycle enables.
// Notes:   Reads take one wait state, writes none.
//
// Functional notes
// - Seven timebase sources, code 110 reserved.
// - Compare timer with primary or both values.
// - Single pulse or pulse train on matches.
// - Matches raise interrupt and DMA request.
// - Center PWM: high at primary, low secondary.
// - Edge PWM: high at zero, low primary.
// - Mode 101: start low, toggle alternately forever.
// - Mode 100: start low, toggle twice, stop.
// - Mode 011: toggle on every primary match.
// - Mode 010: start high, low once.
// - Mode 001: start low, high once.
// - Mode 000 keeps the channel disabled.
// - Compare values double-buffered only in PWM.
// - Trigger flag cleared at secondary match optionally.
//
`timescale 1ns/1ps

module occ_top #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Timebase sources
   input  wire logic [occ_pkg::N_TIMER_TICKS-1:0] timer_ticks,
   input  wire logic                  trigger_generator_output,
   input  wire logic                  cpu_idle,
   // Trigger and faults
   input  wire logic                  trigger_source_in,
   input  wire logic                  fault_a_in,
   input  wire logic                  fault_b_in,
   // Pin and requests
   output logic                       compare_output_pin,
   output logic                       compare_output_oe,
   output logic                       dma_req,
   output logic                       irq
);

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   logic [15:0]               con1_r;
   logic [2:0]                con2_r;
   logic [W-1:0]              pri_r;
   logic [W-1:0]              sec_r;
   logic [W-1:0]              pri_buf_r;
   logic [W-1:0]              sec_buf_r;
   logic [W-1:0]              period_r;
   logic [occ_pkg::IRQ_W-1:0] istat_r;
   logic [occ_pkg::IRQ_W-1:0] imask_r;
   logic [7:0]                addr_r;
   logic                      wr_pend_r;
   logic                      rd_pend_r;
   logic                      pin_r;
   logic                      oe_r;
   logic                      phase_r;
   logic                      done_r;
   logic                      dma_r;
   logic                      irq_r;
   logic                      hresp_r;
   logic [31:0]               hrdata_r;
   logic                      hready_r;

   // --------------------------------------------------------------
   // Decoded controls
   // --------------------------------------------------------------
   occ_pkg::occ_mode_t mode;
   logic [2:0]         tsel;
   logic               pwm;
   logic               dual;
   logic               tick;
   logic               src_tick;
   logic [W-1:0]       count;
   logic               wrap;
   logic               m_pri;
   logic               m_sec;
   logic               m_zero;
   logic               fault_a_set;
   logic               fault_b_set;
   logic               fault_active;
   logic               trig_hw_clr;
   logic               acc;
   logic               we_con1;
   logic               we_con2;
   logic               we_pri;
   logic               we_sec;
   logic               we_timer;
   logic               we_period;
   logic               we_istat;
   logic               we_imask;
   logic [31:0]        rdata;
   logic [occ_pkg::IRQ_W-1:0] ev;

   assign mode = occ_pkg::occ_mode_t'(con1_r[2:0]);
   assign tsel = con1_r[occ_pkg::C1_TSEL_LO +: 3];
   assign pwm  = (mode == occ_pkg::OCC_PWM_EDGE) || (mode == occ_pkg::OCC_PWM_CTR);
   assign dual = (mode == occ_pkg::OCC_DUAL_ONE) || (mode == occ_pkg::OCC_DUAL_CONT) ||
                 (mode == occ_pkg::OCC_PWM_CTR);

   // --------------------------------------------------------------
   // Timebase selection
   // --------------------------------------------------------------
   always_comb begin
      case (tsel)
         occ_pkg::TSEL_PERIPH:   src_tick = 1'b1;
         occ_pkg::TSEL_RESERVED: src_tick = 1'b0;
         occ_pkg::TSEL_TRIGGEN:  src_tick = trigger_generator_output;
         default:                src_tick = timer_ticks[tsel];
      endcase
   end

   // Idle stop freezes the timer but keeps the registers reachable.
   assign tick = src_tick && (mode != occ_pkg::OCC_OFF) &&
                 !(con1_r[occ_pkg::C1_IDLE] && cpu_idle);

   occ_timer #(
      .W (W)
   ) u_timer (
      .clk      (hclk),
      .rst_n    (hresetn),
      .tick     (tick),
      .hold_clr (con2_r[occ_pkg::C2_TGATE] && !con2_r[occ_pkg::C2_TRUN]),
      .load_we  (we_timer),
      .load_val (hwdata[W-1:0]),
      .period   (period_r),
      .count    (count),
      .wrap     (wrap)
   );

   // --------------------------------------------------------------
   // Match events
   // --------------------------------------------------------------
   assign m_pri  = tick && (count == pri_r);
   assign m_sec  = tick && dual && (count == sec_r);
   assign m_zero = tick && (count == '0);

   assign fault_a_set  = pwm && con1_r[occ_pkg::C1_FAEN] && fault_a_in;
   assign fault_b_set  = pwm && con1_r[occ_pkg::C1_FBEN] && fault_b_in;
   assign fault_active = pwm && (con1_r[occ_pkg::C1_FAFLG] || con1_r[occ_pkg::C1_FBFLG]);
   assign trig_hw_clr  = con1_r[occ_pkg::C1_TCLR] && tick && (count == sec_r);

   // --------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------
   assign acc       = hsel && htrans[1] && hready;
   assign we_con1   = wr_pend_r && (addr_r == occ_pkg::OFS_CON1);
   assign we_con2   = wr_pend_r && (addr_r == occ_pkg::OFS_CON2);
   assign we_pri    = wr_pend_r && (addr_r == occ_pkg::OFS_PRI);
   assign we_sec    = wr_pend_r && (addr_r == occ_pkg::OFS_SEC);
   assign we_timer  = wr_pend_r && (addr_r == occ_pkg::OFS_TIMER);
   assign we_period = wr_pend_r && (addr_r == occ_pkg::OFS_PERIOD);
   assign we_istat  = wr_pend_r && (addr_r == occ_pkg::OFS_ISTAT);
   assign we_imask  = wr_pend_r && (addr_r == occ_pkg::OFS_IMASK);

   always_comb begin
      rdata = 32'h0000_0000;
      case (addr_r)
         occ_pkg::OFS_CON1:   rdata = {16'h0000, con1_r};
         occ_pkg::OFS_CON2:   rdata = {29'h0000_0000, con2_r};
         occ_pkg::OFS_PRI:    rdata = 32'(pri_buf_r);
         occ_pkg::OFS_SEC:    rdata = 32'(sec_buf_r);
         occ_pkg::OFS_TIMER:  rdata = 32'(count);
         occ_pkg::OFS_PERIOD: rdata = 32'(period_r);
         occ_pkg::OFS_ISTAT:  rdata = {28'h000_0000, istat_r};
         occ_pkg::OFS_IMASK:  rdata = {28'h000_0000, imask_r};
         default:             rdata = 32'h0000_0000;
      endcase
   end

   // A read waits one cycle so that a write just before it is seen.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r    <= 8'h00;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         hready_r  <= 1'b1;
         hrdata_r  <= 32'h0000_0000;
         hresp_r   <= 1'b0;
      end else begin
         wr_pend_r <= acc && hwrite;
         rd_pend_r <= acc && !hwrite;
         if (acc) begin
            addr_r <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hready_r <= 1'b0;
         end else if (rd_pend_r) begin
            hready_r <= 1'b1;
            hrdata_r <= rdata;
         end
      end
   end

   // --------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         con1_r <= occ_pkg::C1_RESET;
      end else begin
         if (we_con1) begin
            con1_r <= hwdata[15:0] & occ_pkg::C1_MASK;
         end
         if (fault_a_set) begin
            con1_r[occ_pkg::C1_FAFLG] <= 1'b1;
         end
         if (fault_b_set) begin
            con1_r[occ_pkg::C1_FBFLG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         con2_r <= occ_pkg::C2_RESET;
      end else begin
         if (we_con2) begin
            con2_r <= hwdata[2:0];
         end
         if (trig_hw_clr) begin
            con2_r[occ_pkg::C2_TRUN] <= 1'b0;
         end
         // A trigger arriving with a clear still wins.
         if (trigger_source_in) begin
            con2_r[occ_pkg::C2_TRUN] <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------
   // Compare values and period
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pri_buf_r <= '0;
         sec_buf_r <= '0;
         pri_r     <= '0;
         sec_r     <= '0;
         period_r  <= W'(occ_pkg::PERIOD_RESET);
      end else begin
         if (we_pri) begin
            pri_buf_r <= hwdata[W-1:0];
         end
         if (we_sec) begin
            sec_buf_r <= hwdata[W-1:0];
         end
         if (we_period) begin
            period_r <= hwdata[W-1:0];
         end
         if (pwm) begin
            if (wrap) begin
               pri_r <= pri_buf_r;
               sec_r <= sec_buf_r;
            end
         end else begin
            if (we_pri) begin
               pri_r <= hwdata[W-1:0];
            end
            if (we_sec) begin
               sec_r <= hwdata[W-1:0];
            end
         end
      end
   end

   // --------------------------------------------------------------
   // Output pin sequencing
   // --------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_r   <= 1'b0;
         oe_r    <= 1'b0;
         phase_r <= 1'b0;
         done_r  <= 1'b0;
      end else if (we_con1) begin
         oe_r    <= (hwdata[2:0] != occ_pkg::OCC_OFF);
         pin_r   <= (hwdata[2:0] == occ_pkg::OCC_ONE_LOW);
         phase_r <= 1'b0;
         done_r  <= 1'b0;
      end else if (fault_active) begin
         pin_r <= con2_r[occ_pkg::C2_FLVL];
      end else begin
         case (mode)
            occ_pkg::OCC_ONE_HIGH: begin
               if (m_pri && !done_r) begin
                  pin_r  <= 1'b1;
                  done_r <= 1'b1;
               end
            end
            occ_pkg::OCC_ONE_LOW: begin
               if (m_pri && !done_r) begin
                  pin_r  <= 1'b0;
                  done_r <= 1'b1;
               end
            end
            occ_pkg::OCC_TOGGLE: begin
               if (m_pri) begin
                  pin_r <= !pin_r;
               end
            end
            occ_pkg::OCC_DUAL_ONE: begin
               if (!done_r && !phase_r && m_pri) begin
                  pin_r   <= !pin_r;
                  phase_r <= 1'b1;
               end else if (!done_r && phase_r && m_sec) begin
                  pin_r  <= !pin_r;
                  done_r <= 1'b1;
               end
            end
            occ_pkg::OCC_DUAL_CONT: begin
               if ((!phase_r && m_pri) || (phase_r && m_sec)) begin
                  pin_r   <= !pin_r;
                  phase_r <= !phase_r;
               end
            end
            occ_pkg::OCC_PWM_EDGE: begin
               if (m_pri) begin
                  pin_r <= 1'b0;
               end else if (m_zero) begin
                  pin_r <= 1'b1;
               end
            end
            occ_pkg::OCC_PWM_CTR: begin
               if (m_sec) begin
                  pin_r <= 1'b0;
               end else if (m_pri) begin
                  pin_r <= 1'b1;
               end
            end
            default: begin
               pin_r <= 1'b0;
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // Interrupts and DMA
   // --------------------------------------------------------------
   always_comb begin
      ev                     = '0;
      ev[occ_pkg::IRQ_PRI]   = m_pri;
      ev[occ_pkg::IRQ_SEC]   = m_sec;
      ev[occ_pkg::IRQ_FAULT] = fault_a_set || fault_b_set;
      ev[occ_pkg::IRQ_TRIG]  = trig_hw_clr;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         istat_r <= '0;
         imask_r <= '0;
         irq_r   <= 1'b0;
         dma_r   <= 1'b0;
      end else begin
         if (we_imask) begin
            imask_r <= hwdata[occ_pkg::IRQ_W-1:0];
         end
         // Set beats a simultaneous write-one-to-clear.
         istat_r <= (istat_r & ~(we_istat ? hwdata[occ_pkg::IRQ_W-1:0] : '0)) | ev;
         irq_r   <= |(istat_r & imask_r);
         dma_r   <= m_pri || m_sec;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign hrdata             = hrdata_r;
   assign hreadyout          = hready_r;
   assign hresp              = hresp_r;
   assign compare_output_pin = pin_r;
   assign compare_output_oe  = oe_r;
   assign dma_req            = dma_r;
   assign irq                = irq_r;

endmodule

/* testbench/occ_load_model.sv */
// Purpose: Load on the compare pin; counts pin edges and high cycles.
// Assumes: Pin is sampled at rising clock edges.
// Notes:   A released pin shows the inverse of its last level.
`timescale 1ns/1ps
module occ_load_model (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // Pin
   input  wire logic   pin,
   input  wire logic   oe,
   // Observed
   output logic        line,
   output int unsigned n_edge,
   output int unsigned n_high
);
   logic prev_r;
   // Released pin must not look like a held level, so show the inverse.
   assign line = oe ? pin : !prev_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         n_edge <= 0;
         n_high <= 0;
      end else begin
         prev_r <= pin;
         if (oe && pin !== prev_r) n_edge <= n_edge + 1;
         if (oe && pin === 1'b1) n_high <= n_high + 1;
      end
   end
endmodule

/* testbench/occ_top_assertions.sv */
// Purpose: Port-level checks of the output compare channel.
// Assumes: Sees only the top ports; mode and mask are snooped from the bus.
// Notes:   Checks other than a_irq and a_one wait three cycles after a mode write to let it settle.
`timescale 1ns/1ps
module occ_top_assertions (
   // Clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // Outputs
   input wire logic        compare_output_pin,
   input wire logic        compare_output_oe,
   input wire logic        dma_req,
   input wire logic        irq
);
   logic       wq_r;
   logic [7:0] aq_r;
   logic [2:0] mode_r;
   logic       msk_r;
   logic [1:0] age_r;
   logic [1:0] chg_r;
   wire        cw = wq_r && aq_r == 8'h00;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wq_r <= 1'b0;
         aq_r <= 8'h00;
         mode_r <= 3'h0;
         msk_r <= 1'b0;
         age_r <= 2'h3;
         chg_r <= 2'h0;
      end else begin
         wq_r <= hsel && htrans[1] && hready && hwrite;
         aq_r <= haddr[7:0];
         if (cw) mode_r <= hwdata[2:0];
         if (wq_r && aq_r == 8'h1c) msk_r <= |hwdata[3:0];
         age_r <= cw ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
         if (cw) chg_r <= 2'h0;
         else if (age_r != 2'h0 && $changed(compare_output_pin) && chg_r != 2'h3)
            chg_r <= chg_r + 2'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_off;
      age_r == 2'h3 && mode_r == 3'h0 |-> !compare_output_oe && !compare_output_pin && !dma_req;
   endproperty
   a_off: assert property (p_off) else $error("output active while disabled");
   property p_oe;
      age_r == 2'h3 && mode_r != 3'h0 |-> compare_output_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven in active mode");
   property p_dma;
      age_r == 2'h3 && mode_r == 3'h3 && !$changed(compare_output_pin) |-> !dma_req;
   endproperty
   a_dma: assert property (p_dma) else $error("dma request without a compare match");
   property p_irq;
      !msk_r && !$past(msk_r) |-> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt while fully masked");
   property p_hi;
      age_r == 2'h3 && mode_r == 3'h1 |-> !$fell(compare_output_pin);
   endproperty
   a_hi: assert property (p_hi) else $error("pin fell in force-high mode");
   property p_lo;
      age_r == 2'h3 && mode_r == 3'h2 |-> !$rose(compare_output_pin);
   endproperty
   a_lo: assert property (p_lo) else $error("pin rose in force-low mode");
   property p_tog;
      age_r == 2'h3 && mode_r inside {3'h3, 3'h4, 3'h5} && $changed(compare_output_pin)
         |-> dma_req;
   endproperty
   a_tog: assert property (p_tog) else $error("toggle without match request");
   property p_one;
      mode_r == 3'h4 |-> chg_r <= 2'h2;
   endproperty
   a_one: assert property (p_one) else $error("single shot toggled too often");
endmodule
bind occ_top occ_top_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .compare_output_pin, .compare_output_oe, .dma_req, .irq);

/* testbench/occ_top_tb.sv */
// Purpose: Self-checking bench of the output compare channel.
// Assumes: One clock at 125 MHz; the load model counts pin activity.
// Notes:   Windows are whole timer periods so counts are phase independent.
`timescale 1ns/1ps
module occ_top_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic [occ_pkg::N_TIMER_TICKS-1:0] ticks = '0;
   logic        tgo = 1'b0;
   logic        trg = 1'b0;
   logic        fa = 1'b0;
   logic        pin, oe, dma, irq, line;
   int unsigned n_edge, n_high;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;
   logic [31:0] seed = 32'h0000000e;
   occ_top DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .timer_ticks(ticks),
      .trigger_generator_output(tgo), .cpu_idle(1'b0), .trigger_source_in(trg),
      .fault_a_in(fa), .fault_b_in(fa), .compare_output_pin(pin),
      .compare_output_oe(oe), .dma_req(dma), .irq);
   occ_load_model u_load (.clk(hclk), .rst_n(hresetn), .pin, .oe, .line, .n_edge, .n_high);
   initial forever #4 hclk = ~hclk;
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int e_exp(input int m);
      return (m == 3) ? 3 : (m >= 5 ? 6 : 0);
   endfunction
   function automatic int h_exp(input int m, input int p, input int a, input int b);
      return (m == 1) ? 3 * (p + 1) : (m == 6 ? 3 * a : (m == 7 ? 3 * (b - a) : 0));
   endfunction
   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic meas(input int n, output int e, output int h);
      int e0;
      int h0;
      e0 = n_edge;
      h0 = n_high;
      repeat (n) @(posedge hclk);
      e = n_edge - e0;
      h = n_high - h0;
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      int p, a, b, e, h, e0;
      logic [31:0] d;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(occ_pkg::OFS_CON1, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      chk(hresp, 1'b0);
      xfer(occ_pkg::OFS_PERIOD, 1'b0, 32'h0, d);
      chk(d, 32'h0000ffff);
      xfer(8'h20, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      p = 4 + int'(rnd() % 8);
      a = 1 + int'(rnd() % (p / 2));
      b = a + 1 + int'(rnd() % (p - a));
      wr(occ_pkg::OFS_PERIOD, 32'(p));
      wr(occ_pkg::OFS_PRI, 32'(a));
      wr(occ_pkg::OFS_SEC, 32'(b));
      ticks <= '1;
      tgo <= 1'b1;
      for (int t = 0; t < 8; t++) begin
         wr(occ_pkg::OFS_CON1, 32'((t << 10) | 3));
         repeat (2 * (p + 1)) @(posedge hclk);
         meas(3 * (p + 1), e, h);
         chk(e, (t == 6) ? 0 : 3);
      end
      for (int m = 0; m < 8; m++) begin
         wr(occ_pkg::OFS_CON1, 32'h1c00);
         meas(3 * (p + 1), e, h);
         e0 = n_edge;
         wr(occ_pkg::OFS_CON1, 32'(32'h1c00 | m));
         repeat (2 * (p + 1)) @(posedge hclk);
         if (m == 1 || m == 2 || m == 4) chk(n_edge - e0, (m == 1) ? 1 : 2);
         meas(3 * (p + 1), e, h);
         chk(e, e_exp(m));
         if (m != 3 && m != 5) chk(h, h_exp(m, p, a, b));
      end
      wr(occ_pkg::OFS_CON1, 32'h1c03);
      wr(occ_pkg::OFS_IMASK, 32'h1);
      repeat (p + 3) @(posedge hclk);
      chk(irq, 1'b1);
      wr(occ_pkg::OFS_IMASK, 32'h0);
      repeat (2) @(posedge hclk);
      chk(irq, 1'b0);
      wr(occ_pkg::OFS_CON1, 32'h1c00);
      wr(occ_pkg::OFS_ISTAT, 32'hf);
      xfer(occ_pkg::OFS_ISTAT, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      for (int c = 0; c < 2; c++) begin
         wr(occ_pkg::OFS_CON1, 32'(32'h1c03 | (c << 3)));
         trg <= 1'b1;
         @(posedge hclk);
         trg <= 1'b0;
         repeat (2 * (p + 1)) @(posedge hclk);
         xfer(occ_pkg::OFS_CON2, 1'b0, 32'h0, d);
         chk(d[0], c == 0);
      end
      wr(occ_pkg::OFS_CON1, 32'h1c86);
      fa <= 1'b1;
      @(posedge hclk);
      fa <= 1'b0;
      xfer(occ_pkg::OFS_CON1, 1'b0, 32'h0, d);
      chk(d[5:4], 2'h1);
      meas(p + 1, e, h);
      chk(h, 0);
      wr(occ_pkg::OFS_CON1, 32'h1c86);
      xfer(occ_pkg::OFS_CON1, 1'b0, 32'h0, d);
      chk(d[4], 1'b0);
      end_of_test();
   end
endmodule
